/* phrase_trigger_defines.vh */
/*
 * constants for the standalone phrase trigger block: register map, field
 * positions, reset values, timing figures and state codes.
 * assumes it is included by bare name from every design file.
 */
`ifndef PHRASE_TRIGGER_DEFINES_VH
`define PHRASE_TRIGGER_DEFINES_VH

// clock rate and timing figures
`define CLK_MHZ            100
`define DEBOUNCE_TIME_US   16000
`define POR_TIME_US        100

// apb register byte offsets
`define ADDR_W             8
`define REG_CTRL           8'h00
`define REG_PLAY_LEN       8'h04
`define REG_STATUS         8'h08
`define REG_START_COUNT    8'h0C

// control register fields
`define CTRL_STANDBY       0
`define CTRL_RANDOM_EN     1
`define CTRL_STOP          2
`define CTRL_RESET         2'h0

// status register fields
`define ST_PLAYING         0
`define ST_STANDBY         1
`define ST_OSC_XTAL        2
`define ST_DEVSYS          3
`define ST_PHRASE_LO       8
`define ST_PHRASE_HI       14

// playback length, in clock cycles
`define PLAY_LEN_W         24
`define PLAY_LEN_RESET     24'h00C350

// widths
`define PHRASE_W           7
`define SWITCH_W           4
`define SELECT_W           3
`define AUDIO_W            12
`define COUNT_W            16

// random address generator
`define LFSR_W             8
`define LFSR_SEED          8'hA5
`define LFSR_TAPS          8'hB8

// playback states
`define S_IDLE             2'h0
`define S_PLAY             2'h1
`define S_STANDBY          2'h2

`endif

/* phrase_debounce.v */
/*
 * synchronises a group of switch pins, waits a settle time after the last
 * change, then latches the group and pulses a one-cycle strobe.
 * assumes pins are asynchronous to clk; clr restarts it synchronously.
 */
`timescale 1ns/100ps
`include "phrase_trigger_defines.vh"

module phrase_debounce #(
	parameter W     = 4,
	parameter COUNT = 1600000,
	parameter CW    = 21
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          clr,
	input  wire [W-1:0]  din,
	output reg  [W-1:0]  dout,
	output reg           strobe
);

	reg [W-1:0]  sync1_q;
	reg [W-1:0]  sync2_q;
	reg [W-1:0]  seen_q;
	reg [CW-1:0] timer_q;
	reg          armed_q;

	// two-flop synchroniser; only sync2 is looked at afterwards
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= {W{1'b0}};
			sync2_q <= {W{1'b0}};
		end
		else
		begin
			sync1_q <= din;
			sync2_q <= sync1_q;
		end
	end

	// every change restarts the wait, so bounce never latches a half value
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seen_q  <= {W{1'b0}};
			timer_q <= {CW{1'b0}};
			armed_q <= 1'b0;
			dout    <= {W{1'b0}};
			strobe  <= 1'b0;
		end
		else if (clr)
		begin
			seen_q  <= sync2_q;
			timer_q <= {CW{1'b0}};
			armed_q <= 1'b0;
			dout    <= sync2_q;
			strobe  <= 1'b0;
		end
		else
		begin
			strobe <= 1'b0;
			if (sync2_q != seen_q)
			begin
				seen_q  <= sync2_q;
				timer_q <= COUNT[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
				armed_q <= 1'b1;
			end
			else if (armed_q && timer_q == {CW{1'b0}})
			begin
				dout    <= seen_q;
				strobe  <= 1'b1;
				armed_q <= 1'b0;
			end
			else if (armed_q)
			begin
				timer_q <= timer_q - {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // phrase_debounce

/* random_addr_gen.v */
/*
 * free-running galois lfsr used as the random phrase address source.
 * assumes the consumer samples value only when it needs a new address.
 */
`timescale 1ns/100ps
`include "phrase_trigger_defines.vh"

module random_addr_gen #(
	parameter W = `LFSR_W
) (
	input  wire          clk,
	input  wire          rst_n,
	output wire [W-1:0]  value
);

	reg [W-1:0] lfsr_q;
	wire [W-1:0] taps = `LFSR_TAPS;

	// runs every cycle so the sampled value depends on press timing
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			lfsr_q <= `LFSR_SEED;
		else if (lfsr_q[0])
			lfsr_q <= (lfsr_q >> 1) ^ taps;
		else
			lfsr_q <= lfsr_q >> 1;
	end

	assign value = lfsr_q;

endmodule // random_addr_gen

/* standalone_phrase_trigger_control.v */
/*
 * standalone phrase trigger control: turns switch, select and random pins
 * into playback starts, drives busy, the oscillator pins and the audio
 * output level, and offers an apb register port for control and status.
 * assumes pins are asynchronous to pclk and the apb master is on pclk.
 *
// Notes on behaviour
// - reset pin low forces standby and initialisation
// - internal power-on reset holds standby after start
// - busy low while playing, high otherwise
// - type pin high crystal, low rc oscillation
// - second oscillator pin low in standby
// - rc mode: third oscillator pin high standby
// - random pin falling edge plays random phrase
// - random function in use ignores lowest select bit
// - switch change, wait 16 ms, latch, play
 */
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
`include "phrase_trigger_defines.vh"

module standalone_phrase_trigger_control #(
	parameter DEBOUNCE_CYCLES = `DEBOUNCE_TIME_US * `CLK_MHZ,
	parameter POR_CYCLES      = `POR_TIME_US * `CLK_MHZ,
	parameter DEB_CW          = 21,
	parameter POR_CW          = 14
) (
	input  wire                    pclk,
	input  wire                    presetn,
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [`ADDR_W-1:0]      paddr,
	input  wire [31:0]             pwdata,
	output reg  [31:0]             prdata,
	output reg                     pready,
	output reg                     pslverr,
	input  wire                    reset_pin_n,
	input  wire                    osc_type_select,
	input  wire                    osc_pin_in,
	input  wire [`SWITCH_W-1:0]    phrase_switch_in,
	input  wire [`SELECT_W-1:0]    phrase_select_hi,
	input  wire                    random_play_n,
	input  wire                    devsys_link,
	output reg                     busy_n,
	output reg  [`AUDIO_W-1:0]     audio_out,
	output reg                     osc_run,
	output reg                     osc_src_xtal,
	output reg                     osc_pin_out,
	output reg                     osc_pin_rc,
	output reg  [`PHRASE_W-1:0]    phrase_number,
	output reg                     phrase_start
);

	localparam S_IDLE    = `S_IDLE;
	localparam S_PLAY    = `S_PLAY;
	localparam S_STANDBY = `S_STANDBY;

	// synchroniser stages for the loose pins
	reg [4:0]                 pin_s1_q;
	reg [4:0]                 pin_s2_q;
	reg [`SELECT_W-1:0]       sel_s1_q;
	reg [`SELECT_W-1:0]       sel_s2_q;
	reg                       rnd_prev_q;

	reg [POR_CW-1:0]          por_cnt_q;
	reg                       por_active_q;
	reg [1:0]                 ctrl_q;
	reg [`PLAY_LEN_W-1:0]     play_len_q;
	reg [`COUNT_W-1:0]        start_count_q;
	reg [1:0]                 state_q;
	reg [1:0]                 state_d;
	reg [`PLAY_LEN_W-1:0]     play_cnt_q;
	reg [`AUDIO_W-1:0]        tone_q;

	wire [`SWITCH_W-1:0]      sw_latched;
	wire                      sw_strobe;
	wire [`LFSR_W-1:0]        rnd_value;

	// pin_s2_q bits: 0 reset pin, 1 osc type, 2 osc in, 3 random, 4 devsys
	wire reset_pin_s  = pin_s2_q[0];
	wire xtal_sel_s   = pin_s2_q[1];
	wire osc_in_s     = pin_s2_q[2];
	wire random_n_s   = pin_s2_q[3];
	wire devsys_s     = pin_s2_q[4];

	wire standby      = !reset_pin_s || por_active_q || ctrl_q[`CTRL_STANDBY];
	wire random_en    = ctrl_q[`CTRL_RANDOM_EN];
	wire rnd_fall     = rnd_prev_q && !random_n_s && !standby;
	wire sw_start     = sw_strobe && (sw_latched != {`SWITCH_W{1'b0}}) && !standby;
	wire apb_done     = psel && penable && pready;
	wire apb_wr       = apb_done && pwrite;
	wire stop_req     = apb_wr && (paddr == `REG_CTRL) && pwdata[`CTRL_STOP];
	wire [`SELECT_W-1:0] sel_eff;
	wire [`PHRASE_W-1:0] sw_phrase;
	wire [`PHRASE_W-1:0] rnd_phrase;
	wire [`PHRASE_W-1:0] next_phrase;
	wire                 start_req = rnd_fall || sw_start;
	// pitch follows the phrase being played; a stand-in for the decoder
	wire [`PHRASE_W-1:0] tone_step = start_req ? next_phrase : phrase_number;

	// with the random function in use the lowest select pin carries no address
	assign sel_eff    = random_en ? {sel_s2_q[2:1], 1'b0} : sel_s2_q;
	assign sw_phrase  = {sel_eff, sw_latched};
	// random phrase keeps the upper selects; the lowest select is replaced
	assign rnd_phrase = {sel_s2_q[2:1], rnd_value[4:0]};
	// random start wins when both arrive in one cycle
	assign next_phrase = rnd_fall ? rnd_phrase : sw_phrase;

	// two flops before any logic looks at a pin
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1_q <= 5'h08; // random bit starts at its idle high level
			pin_s2_q <= 5'h08;
			sel_s1_q <= 3'h0;
			sel_s2_q <= 3'h0;
			rnd_prev_q <= 1'b1;
		end
		else
		begin
			pin_s1_q <= {devsys_link, random_play_n, osc_pin_in,
				osc_type_select, reset_pin_n};
			pin_s2_q <= pin_s1_q;
			sel_s1_q <= phrase_select_hi;
			sel_s2_q <= sel_s1_q;
			// tracks the pin even in standby: a pin held low is not a new edge
			rnd_prev_q <= random_n_s;
		end
	end

	// power-on reset: holds standby for a fixed time after presetn releases
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			por_cnt_q    <= {POR_CW{1'b0}};
			por_active_q <= 1'b1;
		end
		else if (por_active_q)
		begin
			if (por_cnt_q == POR_CYCLES[POR_CW-1:0] - {{(POR_CW-1){1'b0}}, 1'b1})
				por_active_q <= 1'b0;
			else
				por_cnt_q <= por_cnt_q + {{(POR_CW-1){1'b0}}, 1'b1};
		end
	end

	phrase_debounce #(
		.W     (`SWITCH_W),
		.COUNT (DEBOUNCE_CYCLES),
		.CW    (DEB_CW)
	) u_switch_debounce (
		.clk    (pclk),
		.rst_n  (presetn),
		.clr    (standby),
		.din    (phrase_switch_in),
		.dout   (sw_latched),
		.strobe (sw_strobe)
	);

	random_addr_gen #(
		.W (`LFSR_W)
	) u_random (
		.clk   (pclk),
		.rst_n (presetn),
		.value (rnd_value)
	);

	// playback state: standby dominates, then a new start, then stop
	always @*
	begin
		state_d = state_q;
		case (state_q)
			S_STANDBY:
				if (standby)
					state_d = S_STANDBY;
				else if (start_req)
					state_d = S_PLAY;
				else
					state_d = S_IDLE;
			S_IDLE:
				if (standby)
					state_d = S_STANDBY;
				else if (start_req)
					state_d = S_PLAY;
			S_PLAY:
				if (standby)
					state_d = S_STANDBY;
				else if (start_req)
					state_d = S_PLAY;
				else if (stop_req || play_cnt_q <= {{(`PLAY_LEN_W-1){1'b0}}, 1'b1})
					state_d = S_IDLE;
			default:
				state_d = S_STANDBY;
		endcase
	end

	// a new start during playback restarts with the new phrase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q       <= S_STANDBY;
			play_cnt_q    <= {`PLAY_LEN_W{1'b0}};
			phrase_number <= {`PHRASE_W{1'b0}};
			phrase_start  <= 1'b0;
			start_count_q <= {`COUNT_W{1'b0}};
		end
		else
		begin
			state_q      <= state_d;
			phrase_start <= 1'b0;
			if (standby)
			begin
				play_cnt_q    <= {`PLAY_LEN_W{1'b0}};
				phrase_number <= {`PHRASE_W{1'b0}};
			end
			else if (start_req)
			begin
				play_cnt_q    <= play_len_q;
				phrase_number <= next_phrase;
				phrase_start  <= 1'b1;
				start_count_q <= start_count_q + {{(`COUNT_W-1){1'b0}}, 1'b1};
			end
			else if (state_q == S_PLAY)
			begin
				play_cnt_q <= play_cnt_q - {{(`PLAY_LEN_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// busy, audio and oscillator pins; audio is grounded outside playback
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_n       <= 1'b1;
			audio_out    <= {`AUDIO_W{1'b0}};
			tone_q       <= {`AUDIO_W{1'b0}};
			osc_run      <= 1'b0;
			osc_src_xtal <= 1'b0;
			osc_pin_out  <= 1'b0;
			osc_pin_rc   <= 1'b0;
		end
		else
		begin
			busy_n       <= !(state_d == S_PLAY);
			osc_src_xtal <= xtal_sel_s;
			osc_run      <= !standby;
			if (state_d == S_PLAY)
				tone_q <= tone_q + {{(`AUDIO_W-`PHRASE_W-1){1'b0}}, tone_step, 1'b1};
			else
				tone_q <= {`AUDIO_W{1'b0}};
			audio_out <= (state_d == S_PLAY) ? tone_q : {`AUDIO_W{1'b0}};
			if (standby)
			begin
				osc_pin_out <= 1'b0;
				osc_pin_rc  <= !xtal_sel_s;
			end
			else
			begin
				// running: osc_pin_out, and osc_pin_rc in rc mode, act as the inverting stage of the oscillator
				osc_pin_out <= !osc_in_s;
				osc_pin_rc  <= xtal_sel_s ? 1'b0 : !osc_in_s;
			end
		end
	end

	// apb slave: one wait state, writes take effect at the completing edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h00000000;
			ctrl_q     <= `CTRL_RESET;
			play_len_q <= `PLAY_LEN_RESET;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			if (psel && penable && !pready)
			begin
				prdata <= 32'h00000000;
				case (paddr)
					`REG_CTRL:
						prdata[1:0] <= ctrl_q;
					`REG_PLAY_LEN:
						prdata[`PLAY_LEN_W-1:0] <= play_len_q;
					`REG_STATUS:
					begin
						prdata[`ST_PLAYING]  <= (state_q == S_PLAY);
						prdata[`ST_STANDBY]  <= standby;
						prdata[`ST_OSC_XTAL] <= xtal_sel_s;
						prdata[`ST_DEVSYS]   <= devsys_s;
						prdata[`ST_PHRASE_HI:`ST_PHRASE_LO] <= phrase_number;
					end
					`REG_START_COUNT:
						prdata[`COUNT_W-1:0] <= start_count_q;
					default:
						pslverr <= 1'b1;
				endcase
			end
			if (apb_wr && paddr == `REG_CTRL)
				ctrl_q <= pwdata[1:0];
			if (apb_wr && paddr == `REG_PLAY_LEN)
				play_len_q <= pwdata[`PLAY_LEN_W-1:0];
		end
	end

endmodule // standalone_phrase_trigger_control

/* phrase_trigger_chk.sv */
/*
 * port checker for the phrase trigger control.
 * assumes it is bound onto the top module and shares its clock and reset.
 */
`timescale 1ns/100ps
module phrase_trigger_chk #(
	parameter POR_CYCLES = 8
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        reset_pin_n,
	input wire        busy_n,
	input wire [11:0] audio_out,
	input wire        osc_run,
	input wire        osc_src_xtal,
	input wire        osc_pin_out,
	input wire        osc_pin_rc,
	input wire        phrase_start
);
	reg [15:0] por_q;

	// cycles since reset release; saturates so long runs never wrap
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			por_q <= 16'h0000;
		else if (por_q != 16'hFFFF)
			por_q <= por_q + 16'h0001;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_por_hold: assert property (por_q < POR_CYCLES |-> !osc_run)
		else $error("standby left before power-on time");
	a_pin_standby: assert property (!reset_pin_n [*5] |-> !osc_run)
		else $error("reset pin did not force standby");
	a_audio_ground: assert property (!osc_run && !$past(osc_run) |-> audio_out == 12'h000)
		else $error("audio not grounded in standby");
	a_standby_idle: assert property (!osc_run && !$past(osc_run) |-> busy_n)
		else $error("busy low in standby");
	a_osc_pin_out_low: assert property (!osc_run && !$past(osc_run) |-> !osc_pin_out)
		else $error("second oscillator pin high in standby");
	// wait a few cycles after reset so the type sync has settled
	a_rc_high: assert property (por_q > 16'h0003 && !osc_run && !$past(osc_run)
		&& !osc_src_xtal && !$past(osc_src_xtal) |-> osc_pin_rc)
		else $error("third oscillator pin low in rc standby");
	a_xtal_low: assert property (por_q > 16'h0003 && !osc_run && !$past(osc_run)
		&& osc_src_xtal && $past(osc_src_xtal) |-> !osc_pin_rc)
		else $error("third oscillator pin high in crystal standby");
	a_start_busy: assert property (phrase_start |-> !busy_n)
		else $error("start without busy");
	a_busy_cause: assert property ($fell(busy_n) |-> phrase_start)
		else $error("busy fell without a start");
	a_apb_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	a_ready_qual: assert property (pready |-> psel && penable)
		else $error("pready outside an access");
endmodule // phrase_trigger_chk

bind standalone_phrase_trigger_control phrase_trigger_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.reset_pin_n(reset_pin_n), .busy_n(busy_n), .audio_out(audio_out), .osc_run(osc_run),
	.osc_src_xtal(osc_src_xtal), .osc_pin_out(osc_pin_out), .osc_pin_rc(osc_pin_rc),
	.phrase_start(phrase_start)
);

/* phrase_pins_model.sv */
/*
 * push switches and a random button on the phrase pins.
 * assumes the bench sets sw_set and rnd_press just after a clock edge.
 */
`timescale 1ns/100ps
module phrase_pins_model (
	input  wire       clk,
	input  wire [3:0] sw_set,
	input  wire       rnd_press,
	output reg  [3:0] phrase_switch_in,
	output wire       random_play_n
);
	reg [3:0] left_q;

	initial left_q = 4'h0;
	initial phrase_switch_in = 4'h0; // pull-down level

	// contacts chatter for some cycles before they settle, so one press
	// looks like several changes to the block
	always @(posedge clk)
		if (left_q != 4'h0)
		begin
			left_q <= left_q - 4'h1;
			phrase_switch_in <= (left_q == 4'h1) ? sw_set : ~phrase_switch_in;
		end
		else if (sw_set != phrase_switch_in)
			left_q <= 4'h6;

	assign random_play_n = ~rnd_press;
endmodule // phrase_pins_model

/* standalone_phrase_trigger_control_tb_top.sv */
/*
 * bench for the phrase trigger control: apb master, pin stimulus, switches.
 * assumes short debounce and power-on counts set at the instance.
 */
`timescale 1ns/100ps
module standalone_phrase_trigger_control_tb_top;
	reg         pclk, presetn, psel, penable, pwrite, reset_pin_n, err;
	reg         osc_type_select, osc_pin_in, devsys_link, rnd_press;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata, rd;
	reg  [3:0]  sw_set;
	reg  [2:0]  phrase_select_hi;
	wire [31:0] prdata;
	wire        pready, pslverr, busy_n, osc_run, osc_src_xtal, osc_pin_out;
	wire        osc_pin_rc, phrase_start, random_play_n;
	wire [11:0] audio_out;
	wire [6:0]  phrase_number;
	wire [3:0]  phrase_switch_in;
	integer     num_errors, checks, n;

	always #5 pclk = ~pclk;
	// oscillator pin keeps toggling so its paths see activity
	always @(posedge pclk) osc_pin_in <= ~osc_pin_in;

	standalone_phrase_trigger_control #(.DEBOUNCE_CYCLES(20), .POR_CYCLES(8)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reset_pin_n(reset_pin_n), .osc_type_select(osc_type_select),
		.osc_pin_in(osc_pin_in), .phrase_switch_in(phrase_switch_in),
		.phrase_select_hi(phrase_select_hi), .random_play_n(random_play_n),
		.devsys_link(devsys_link), .busy_n(busy_n), .audio_out(audio_out),
		.osc_run(osc_run), .osc_src_xtal(osc_src_xtal), .osc_pin_out(osc_pin_out),
		.osc_pin_rc(osc_pin_rc), .phrase_number(phrase_number), .phrase_start(phrase_start));
	phrase_pins_model u_pins (.clk(pclk), .sw_set(sw_set), .rnd_press(rnd_press),
		.phrase_switch_in(phrase_switch_in), .random_play_n(random_play_n));

	task end_sim;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input ok, input [8*8-1:0] what);
		checks = checks + 1;
		if (ok !== 1'b1)
		begin
			num_errors = num_errors + 1;
			$display("BAD %0t %0s", $time, what);
		end
	endtask

	// one apb transfer; request held until pready is seen high
	task apb(input w, input [7:0] a, input [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n = n + 1;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(n < 20, "apb");
		if (n >= 20)
			end_sim;
		@(posedge pclk); // idle edge: a following call never re-drives psel in this step
	endtask

	// waits at least one edge for start (0), idle busy (1) or running (2)
	task wait_on(input integer s, input integer lim);
		n = 0;
		do
		begin
			@(posedge pclk);
			n = n + 1;
		end
		while (n < lim && (s == 0 ? phrase_start : s == 1 ? busy_n : osc_run) !== 1'b1);
		chk(n < lim, "timeout");
		if (n >= lim)
			end_sim;
	endtask

	task t_regs;
		apb(1'b0, 8'h04, 32'h00000000);
		chk(rd === 32'h0000C350 && err === 1'b0, "len");
		apb(1'b0, 8'h08, 32'h00000000);
		chk(rd[3] === 1'b1, "status");
		apb(1'b0, 8'h10, 32'h00000000);
		chk(err === 1'b1 && rd === 32'h00000000, "unmap");
		apb(1'b1, 8'h04, 32'h00000028);
		apb(1'b0, 8'h04, 32'h00000000);
		chk(rd === 32'h00000028, "len");
	endtask

	task t_switch;
		phrase_select_hi <= 3'h5;
		sw_set <= 4'hA;
		wait_on(0, 300);
		chk(n >= 20 && phrase_number === 7'h5A, "switch");
		chk(busy_n === 1'b0, "busy");
		wait_on(1, 300);
		chk(n == 40, "length");
	endtask

	task t_random;
		apb(1'b1, 8'h00, 32'h00000002);
		phrase_select_hi <= 3'h7;
		rnd_press <= 1'b1;
		wait_on(0, 20);
		chk(phrase_number[6:5] === 2'h3 && busy_n === 1'b0, "random");
		rnd_press <= 1'b0;
		phrase_select_hi <= 3'h1;
		sw_set <= 4'h3;
		wait_on(0, 300);
		chk(phrase_number === 7'h03, "mask");
		apb(1'b0, 8'h08, 32'h00000000);
		chk(rd[14:8] === 7'h03 && rd[0] === 1'b1, "stat");
		apb(1'b1, 8'h00, 32'h00000004);
		wait_on(1, 10);
		apb(1'b0, 8'h0C, 32'h00000000);
		chk(rd === 32'h00000003, "starts");
	endtask

	task t_standby;
		integer t;
		for (t = 0; t < 2; t = t + 1)
		begin
			osc_type_select <= t[0];
			rnd_press <= 1'b1;
			wait_on(0, 20);
			rnd_press <= 1'b0;
			reset_pin_n <= 1'b0;
			repeat (6) @(posedge pclk);
			chk(osc_run === 1'b0 && audio_out === 12'h000, "standby");
			chk(busy_n === 1'b1, "busy");
			chk(osc_pin_out === 1'b0 && osc_pin_rc === !t[0], "osc");
			reset_pin_n <= 1'b1;
			wait_on(2, 20);
		end
		apb(1'b1, 8'h00, 32'h00000001);
		apb(1'b0, 8'h08, 32'h00000000);
		chk(rd[1:0] === 2'h2 && osc_run === 1'b0, "ctrlsb");
		apb(1'b1, 8'h00, 32'h00000000);
		wait_on(2, 20);
	endtask

	initial
	begin
		{pclk, presetn, psel, penable, pwrite, osc_pin_in, rnd_press} = 7'h00;
		{reset_pin_n, osc_type_select, devsys_link} = 3'h7;
		{paddr, pwdata, sw_set, phrase_select_hi} = 47'h0;
		num_errors = 0;
		checks = 0;
		repeat (6) @(posedge pclk);
		chk(busy_n === 1'b1, "busy");
		presetn <= 1'b1;
		wait_on(2, 100);
		chk(n >= 8, "por");
		t_regs;
		t_switch;
		t_random;
		t_standby;
		end_sim;
	end
endmodule // standalone_phrase_trigger_control_tb_top
